/* File: rx_pkg.sv */
`default_nettype none

package rx_pkg;

    // Core clock rate and oversampling of the receive bit clock.
    localparam int CLK_HZ = 10_000_000;
    localparam int OVERSAMPLE = 16;

    // Tick counts within a bit: half a bit and one full bit of 16x ticks.
    localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
    localparam logic [3:0] FULL_BIT_TICKS = 4'hF;

    // Positions within the serial configuration switches (switch n is bit n-1).
    localparam int SW_WORD7 = 0;
    localparam int SW_PARITY_OFF = 1;
    localparam int SW_EVEN = 2;
    localparam int SW_RATE_LSB = 4;
    localparam int SW_RATE_SPARE = 7;

    // Position of the input buffer size switch in the general switches (off = large).
    localparam int GEN_SMALL_BUFFER = 3;

    // Software flow control codes and buffer thresholds in bytes.
    localparam logic [7:0] XOFF_CODE = 8'h13;
    localparam logic [7:0] XON_CODE = 8'h11;
    localparam logic [12:0] XOFF_FREE_BYTES = 13'h0400;
    localparam logic [12:0] XON_USED_BYTES = 13'h0800;

    // Transmit frame: start, eight data bits, one stop.
    localparam logic [3:0] TX_FRAME_BITS = 4'hA;

    // Reset values.
    localparam logic [7:0] SWITCHES_RST = 8'h00;
    localparam logic [12:0] DIV_RST = 13'h0000;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

    // Clock cycles per 16x tick for a three-bit rate code.
    function automatic logic [12:0] tick_div(input int clk_hz, input logic [2:0] code);
        int rate;
        rate = 9600;
        case (code)
            3'h0: rate = 110;
            3'h1: rate = 150;
            3'h2: rate = 300;
            3'h3: rate = 600;
            3'h4: rate = 1200;
            3'h5: rate = 2400;
            3'h6: rate = 4800;
            default: rate = 9600;
        endcase
        tick_div = 13'(clk_hz / (OVERSAMPLE * rate));
    endfunction

endpackage

`default_nettype wire

/* File: baud_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module baud_tick_gen #(
    parameter int CLK_HZ = rx_pkg::CLK_HZ
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] rate_code_in,
    output logic tick_out
);

    logic [12:0] count_q;
    logic [12:0] div_q;

    ////////////////////////////////////////////////////////////////////////////
    // The divisor is registered so the division stays off the count path.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
            div_q <= rx_pkg::DIV_RST;
        else
            div_q <= rx_pkg::tick_div(CLK_HZ, rate_code_in);
    end

    // Free-running down counter; one enable pulse per reload.
    // A count above a new divisor reloads at once, so a stale slow count cannot stall ticks.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            count_q <= rx_pkg::DIV_RST;
            tick_out <= 1'b0;
        end
        else if (count_q == 13'h0000 || count_q >= div_q)
        begin
            count_q <= (div_q == 13'h0000) ? 13'h0000 : div_q - 13'h0001;
            tick_out <= 1'b1;
        end
        else
        begin
            count_q <= count_q - 13'h0001;
            tick_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: serial_rx_top.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_rx_top #(
    parameter int CLK_HZ = rx_pkg::CLK_HZ
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic rxd_in,
    input wire logic [7:0] serial_config_switches_in,
    input wire logic [7:0] general_config_switches_in,
    input wire logic line_key_in,
    input wire logic host_reset_n_in,
    input wire logic mech_fault_in,
    input wire logic online_in,
    input wire logic decoder_busy_in,
    input wire logic [12:0] buf_free_in,
    input wire logic [12:0] buf_used_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic alarm_lamp_out,
    output logic buzzer_out,
    output logic fault_out,
    output logic busy_out,
    output logic td_out
);

    logic rx_meta_q, rx_sync_q, rx_prev_q, key_meta_q, key_sync_q, key_prev_q;
    logic hrst_meta_q, hrst_sync_q, cfg_loaded_q, word7_q, parity_en_q, even_q, large_buf_q;
    logic [7:0] ser_meta_q, ser_sync_q, gen_meta_q, gen_sync_q, shift_q, char_data;
    logic [2:0] rate_q, bit_idx_q;
    logic [3:0] tick_cnt_q, tx_bits_q, tx_tick_q;
    logic tick, parity_err_q, overrun_q, frame_done, frame_err, comm_alarm_q, fault_q;
    logic key_press, rx_enable, xoff_sent_q, tx_active_q;
    rx_pkg::rx_state_e state_q;
    logic [9:0] tx_shift_q;

    ////////////////////////////////////////////////////////////////////////////
    // The line, key, host reset and switch inputs pass two flip-flops; logic reads the second, plus a third stage for line and key edges.
    // The switch chains run through reset, so the settings are valid at release.
    always_ff @(posedge core_clk_in)
    begin
        ser_meta_q <= serial_config_switches_in;
        ser_sync_q <= ser_meta_q;
        gen_meta_q <= general_config_switches_in;
        gen_sync_q <= gen_meta_q;
        if (!rst_n_in)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
            key_meta_q <= 1'b0;
            key_sync_q <= 1'b0;
            key_prev_q <= 1'b0;
            hrst_meta_q <= 1'b1;
            hrst_sync_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= rxd_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
            key_meta_q <= line_key_in;
            key_sync_q <= key_meta_q;
            key_prev_q <= key_sync_q;
            hrst_meta_q <= host_reset_n_in;
            hrst_sync_q <= hrst_meta_q;
        end
    end

    assign key_press = key_sync_q & ~key_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Settings latch on the first edge after release; later switch changes are ignored.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            cfg_loaded_q <= 1'b0;
            word7_q <= 1'b0;
            parity_en_q <= 1'b0;
            even_q <= 1'b0;
            rate_q <= 3'h0;
            large_buf_q <= 1'b0;
        end
        else if (!cfg_loaded_q)
        begin
            cfg_loaded_q <= 1'b1;
            word7_q <= ser_sync_q[rx_pkg::SW_WORD7];
            parity_en_q <= ~ser_sync_q[rx_pkg::SW_PARITY_OFF];
            even_q <= ser_sync_q[rx_pkg::SW_EVEN];
            rate_q <= ser_sync_q[rx_pkg::SW_RATE_LSB +: 3];
            large_buf_q <= ~gen_sync_q[rx_pkg::GEN_SMALL_BUFFER];
        end
    end

    // Switch 8 is expected off; its state does not alter the rate.
    baud_tick_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .rate_code_in(rate_q),
        .tick_out(tick)
    );

    // Receiving waits for settings, online state and a cleared fault.
    assign rx_enable = cfg_loaded_q & online_in & ~fault_q;
    assign busy_out = ~cfg_loaded_q | ~online_in | fault_q | decoder_busy_in;

    ////////////////////////////////////////////////////////////////////////////
    // Receive sequencer in 16x ticks.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= rx_pkg::RX_IDLE;
            tick_cnt_q <= 4'h0;
            bit_idx_q <= 3'h0;
            shift_q <= 8'h00;
            parity_err_q <= 1'b0;
            overrun_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                rx_pkg::RX_IDLE:
                begin
                    tick_cnt_q <= 4'h0;
                    if (rx_enable && rx_prev_q && !rx_sync_q)
                        state_q <= rx_pkg::RX_START;
                end
                rx_pkg::RX_START:
                begin
                    if (tick && tick_cnt_q == rx_pkg::HALF_BIT_TICKS)
                    begin
                        tick_cnt_q <= 4'h0;
                        bit_idx_q <= 3'h0;
                        parity_err_q <= 1'b0;
                        overrun_q <= busy_out;
                        // A mark here was noise: restart quietly.
                        state_q <= rx_sync_q ? rx_pkg::RX_IDLE : rx_pkg::RX_DATA;
                    end
                    else if (tick)
                        tick_cnt_q <= tick_cnt_q + 4'h1;
                end
                rx_pkg::RX_DATA:
                begin
                    if (tick && tick_cnt_q == rx_pkg::FULL_BIT_TICKS)
                    begin
                        tick_cnt_q <= 4'h0;
                        shift_q <= {rx_sync_q, shift_q[7:1]};
                        bit_idx_q <= bit_idx_q + 3'h1;
                        if (bit_idx_q == (word7_q ? 3'h6 : 3'h7))
                            state_q <= parity_en_q ? rx_pkg::RX_PARITY : rx_pkg::RX_STOP;
                    end
                    else if (tick)
                        tick_cnt_q <= tick_cnt_q + 4'h1;
                end
                rx_pkg::RX_PARITY:
                begin
                    if (tick && tick_cnt_q == rx_pkg::FULL_BIT_TICKS)
                    begin
                        tick_cnt_q <= 4'h0;
                        // Odd sense wants an odd count of ones including parity.
                        parity_err_q <= ((^char_data) ^ rx_sync_q) == even_q;
                        state_q <= rx_pkg::RX_STOP;
                    end
                    else if (tick)
                        tick_cnt_q <= tick_cnt_q + 4'h1;
                end
                rx_pkg::RX_STOP:
                begin
                    if (tick && tick_cnt_q == rx_pkg::FULL_BIT_TICKS)
                        state_q <= rx_pkg::RX_IDLE;
                    else if (tick)
                        tick_cnt_q <= tick_cnt_q + 4'h1;
                end
                default:
                    state_q <= rx_pkg::RX_IDLE;
            endcase
        end
    end

    // Seven-bit words were shifted in one place short of the bottom.
    assign char_data = word7_q ? {1'b0, shift_q[7:1]} : shift_q;
    assign frame_done = state_q == rx_pkg::RX_STOP && tick
        && tick_cnt_q == rx_pkg::FULL_BIT_TICKS;
    assign frame_err = frame_done && (!rx_sync_q || parity_err_q || overrun_q);

    ////////////////////////////////////////////////////////////////////////////
    // Good characters go out with a one-cycle strobe; bad ones are dropped.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_data_out <= 8'h00;
            rx_valid_out <= 1'b0;
        end
        else
        begin
            rx_valid_out <= frame_done && !frame_err;
            if (frame_done && !frame_err)
                rx_data_out <= char_data;
        end
    end

    // Alarms: a new event in the clearing cycle wins over the key press.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            comm_alarm_q <= 1'b0;
            fault_q <= 1'b0;
            buzzer_out <= 1'b0;
        end
        else
        begin
            if (frame_err)
                comm_alarm_q <= 1'b1;
            else if (key_press)
                comm_alarm_q <= 1'b0;
            if (mech_fault_in)
                fault_q <= 1'b1;
            else if (key_press || !hrst_sync_q)
                fault_q <= 1'b0;
            buzzer_out <= frame_err || (mech_fault_in && !fault_q);
        end
    end

    assign alarm_lamp_out = comm_alarm_q | fault_q;
    assign fault_out = fault_q;

    ////////////////////////////////////////////////////////////////////////////
    // Flow-control transmitter: 8N1 frames at the selected rate, idle mark.
    // Only one code is in flight at a time, so thresholds are rechecked after.
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            xoff_sent_q <= 1'b0;
            tx_active_q <= 1'b0;
            tx_shift_q <= 10'h3FF;
            tx_bits_q <= 4'h0;
            tx_tick_q <= 4'h0;
            td_out <= 1'b1;
        end
        else if (!tx_active_q)
        begin
            td_out <= 1'b1;
            tx_tick_q <= 4'h0;
            tx_bits_q <= 4'h0;
            if (large_buf_q && (xoff_sent_q ? (buf_used_in <= rx_pkg::XON_USED_BYTES)
                : (buf_free_in < rx_pkg::XOFF_FREE_BYTES)))
            begin
                tx_shift_q <= xoff_sent_q ? {1'b1, rx_pkg::XON_CODE, 1'b0}
                    : {1'b1, rx_pkg::XOFF_CODE, 1'b0};
                xoff_sent_q <= ~xoff_sent_q;
                tx_active_q <= 1'b1;
            end
        end
        else if (tick)
        begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == 4'h0)
            begin
                td_out <= tx_shift_q[0];
                tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            end
            if (tx_tick_q == rx_pkg::FULL_BIT_TICKS)
            begin
                tx_bits_q <= tx_bits_q + 4'h1;
                if (tx_bits_q == rx_pkg::TX_FRAME_BITS - 4'h1)
                    tx_active_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: serial_rx_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_rx_chk (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic mech_fault_in,
    input wire logic online_in,
    input wire logic decoder_busy_in,
    input wire logic [7:0] rx_data_out,
    input wire logic rx_valid_out,
    input wire logic alarm_lamp_out,
    input wire logic buzzer_out,
    input wire logic fault_out,
    input wire logic busy_out,
    input wire logic td_out
);
    // One clock domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Pulses must stay one cycle wide, or the decoder would take a character twice.
    AST_VALID_PULSE: assert property (rx_valid_out |=> !rx_valid_out)
        else $error("valid strobe wider than one cycle");
    AST_BUZZ_PULSE: assert property (buzzer_out |=> !buzzer_out)
        else $error("buzzer pulse wider than one cycle");
    AST_BUZZ_ALARM: assert property (buzzer_out |-> alarm_lamp_out && !rx_valid_out)
        else $error("error pulse without lamp or with a delivered character");
    AST_RESET_VALUES: assert property (!$past(rst_n_in) |-> !rx_valid_out && !alarm_lamp_out
        && !fault_out && td_out && busy_out)
        else $error("outputs not at rest after reset");
    AST_DATA_HOLD: assert property ($past(rst_n_in) && !rx_valid_out |-> $stable(rx_data_out))
        else $error("received data changed without a strobe");

    ////////////////////////////////////////////////////////////////////////////////
    // Fault handling: the set side always wins over any clear request.
    AST_FAULT_SET: assert property (mech_fault_in |=> fault_out && alarm_lamp_out && busy_out)
        else $error("fault not reflected on outputs");
    AST_FAULT_ONSET: assert property (mech_fault_in && !fault_out |=> buzzer_out)
        else $error("no buzzer at fault onset");
    AST_FAULT_HOLD: assert property (fault_out && mech_fault_in |=> fault_out && alarm_lamp_out)
        else $error("fault dropped while cause present");
    AST_BUSY_GATE: assert property (!online_in || decoder_busy_in || fault_out |-> busy_out)
        else $error("ready shown while unable to receive");
endmodule

bind serial_rx_top serial_rx_chk i_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mech_fault_in(mech_fault_in),
    .online_in(online_in), .decoder_busy_in(decoder_busy_in), .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out), .alarm_lamp_out(alarm_lamp_out), .buzzer_out(buzzer_out),
    .fault_out(fault_out), .busy_out(busy_out), .td_out(td_out)
);

`default_nettype wire

/* File: host_tx.sv */
`timescale 1ns/100ps
`default_nettype none

module host_tx #(
    parameter int BIT_CYC = 160
) (
    input wire logic core_clk_in,
    input wire logic busy_in,
    output logic rxd_out
);
    // The line rests at mark between characters.
    initial rxd_out = 1'b1;

    // Sends start, n bits LSB first, the given stop level, then one mark bit.
    task automatic send(input logic [8:0] bits, input int n, input logic stop, input logic force_tx);
        logic [11:0] f;
        int i;
        i = 0;
        while (!force_tx && busy_in !== 1'b0 && i < 5000)
        begin
            @(negedge core_clk_in);
            i++;
        end
        f = 12'hFFF;
        f[0] = 1'b0;
        for (i = 0; i < n; i++)
            f[i + 1] = bits[i];
        f[n + 1] = stop;
        for (i = 0; i < n + 3; i++)
        begin
            @(negedge core_clk_in);
            rxd_out = f[i];
            repeat (BIT_CYC - 1) @(negedge core_clk_in);
        end
    endtask

    // A space blip shorter than half a bit, as line noise would give.
    task automatic glitch(input int cyc);
        @(negedge core_clk_in);
        rxd_out = 1'b0;
        repeat (cyc) @(negedge core_clk_in);
        rxd_out = 1'b1;
        repeat (BIT_CYC * 2) @(negedge core_clk_in);
    endtask
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
    // A slow core clock keeps 9600 baud at 10 cycles a tick, 160 a bit.
    localparam int CLK_HZ = 1536000;
    localparam int BIT_CYC = 160;
    logic core_clk_in, rst_n_in, rxd, key, host_rst_n, mech_fault, online, dec_busy;
    logic [7:0] ser_cfg, gen_cfg, rx_data_out, last_data, d, cfg;
    logic [12:0] buf_free, buf_used;
    logic rx_valid_out, alarm_lamp_out, buzzer_out, fault_out, busy_out, td_out, p;
    int mismatches, comparisons, valid_cnt, buzz_cnt, v0, b0, k, n;

    serial_rx_top #(.CLK_HZ(CLK_HZ)) i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .rxd_in(rxd), .serial_config_switches_in(ser_cfg), .general_config_switches_in(gen_cfg),
        .line_key_in(key), .host_reset_n_in(host_rst_n), .mech_fault_in(mech_fault),
        .online_in(online), .decoder_busy_in(dec_busy), .buf_free_in(buf_free),
        .buf_used_in(buf_used), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .alarm_lamp_out(alarm_lamp_out), .buzzer_out(buzzer_out), .fault_out(fault_out),
        .busy_out(busy_out), .td_out(td_out));
    host_tx #(.BIT_CYC(BIT_CYC)) h (.core_clk_in(core_clk_in), .busy_in(busy_out), .rxd_out(rxd));

    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counting at the falling edge avoids racing the design's own updates.
    always @(negedge core_clk_in)
    begin
        valid_cnt += int'(rx_valid_out === 1'b1);
        buzz_cnt += int'(buzzer_out === 1'b1);
        if (rx_valid_out === 1'b1)
            last_data = rx_data_out;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Switches settle during reset because they are latched at release.
    task automatic do_reset(input logic [7:0] c);
        @(negedge core_clk_in);
        rst_n_in = 1'b0;
        ser_cfg = c;
        repeat (4) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
    endtask

    task automatic press_key();
        @(negedge core_clk_in);
        key = 1'b1;
        repeat (4) @(negedge core_clk_in);
        key = 1'b0;
        repeat (4) @(negedge core_clk_in);
    endtask

    task automatic snap();
        v0 = valid_cnt;
        b0 = buzz_cnt;
    endtask

    task automatic counts(input int dv, input int db);
        check(16'(valid_cnt - v0), 16'(dv));
        check(16'(buzz_cnt - b0), 16'(db));
    endtask

    // Samples one flow-control frame on the transmit line at mid-bit.
    task automatic get_td(input logic [7:0] exp);
        logic [9:0] f;
        int i;
        i = 0;
        while (td_out !== 1'b0 && i < 3000)
        begin
            @(negedge core_clk_in);
            i++;
        end
        repeat (BIT_CYC / 2) @(negedge core_clk_in);
        for (i = 0; i < 10; i++)
        begin
            f[i] = td_out;
            repeat (BIT_CYC) @(negedge core_clk_in);
        end
        check({6'h00, f}, {6'h00, 1'b1, exp, 1'b0});
    endtask

    initial
    begin
        repeat (90000) @(posedge core_clk_in);
        mismatches++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n_in, key, mech_fault, dec_busy} = 4'h0;
        {host_rst_n, online} = 2'h3;
        {mismatches, comparisons, valid_cnt, buzz_cnt} = 0;
        ser_cfg = 8'h72;
        gen_cfg = 8'h00;
        buf_free = 13'h1FFF;
        buf_used = 13'h0000;
        do_reset(8'h72);
        check(16'(busy_out), 16'h0000);
        snap();
        h.send(9'h0A5, 8, 1'b1, 1'b0);
        check(16'(last_data), 16'h00A5);
        ser_cfg = 8'h01;
        h.send(9'h05A, 8, 1'b1, 1'b0);
        check(16'(last_data), 16'h005A);
        counts(2, 0);
        $display("test basic done");
        snap();
        h.send(9'h0A5, 8, 1'b0, 1'b0);
        h.send(9'h03C, 8, 1'b1, 1'b0);
        counts(1, 1);
        check(16'(last_data), 16'h003C);
        check(16'(alarm_lamp_out), 16'h0001);
        press_key();
        check(16'(alarm_lamp_out), 16'h0000);
        h.glitch(BIT_CYC / 4);
        counts(1, 1);
        $display("test framing done");
        snap();
        dec_busy = 1'b1;
        h.send(9'h0C3, 8, 1'b1, 1'b1);
        dec_busy = 1'b0;
        counts(0, 1);
        check(16'(alarm_lamp_out), 16'h0001);
        press_key();
        $display("test overrun done");
        snap();
        mech_fault = 1'b1;
        repeat (2) @(negedge core_clk_in);
        check(16'({fault_out, alarm_lamp_out, busy_out}), 16'h0007);
        press_key();
        check(16'(fault_out), 16'h0001);
        mech_fault = 1'b0;
        online = 1'b0;
        host_rst_n = 1'b0;
        repeat (4) @(negedge core_clk_in);
        host_rst_n = 1'b1;
        check(16'({fault_out, alarm_lamp_out, busy_out}), 16'h0001);
        h.send(9'h011, 8, 1'b1, 1'b1);
        online = 1'b1;
        h.send(9'h022, 8, 1'b1, 1'b0);
        counts(1, 1);
        check(16'(last_data), 16'h0022);
        $display("test fault done");
        buf_free = 13'h0400;
        buf_used = 13'h0801;
        repeat (40) @(negedge core_clk_in);
        check(16'(td_out), 16'h0001);
        buf_free = 13'h03FF;
        get_td(8'h13);
        buf_free = 13'h1FFF;
        repeat (40) @(negedge core_clk_in);
        check(16'(td_out), 16'h0001);
        buf_used = 13'h0800;
        get_td(8'h11);
        $display("test flow done");
        for (k = 0; k < 5; k++)
        begin
            cfg = (k == 4) ? 8'h73 : 8'h70 | 8'(k[0]) | (8'(k[1]) << 2);
            do_reset(cfg);
            n = cfg[0] ? 7 : 8;
            d = 8'hC3 & (cfg[0] ? 8'h7F : 8'hFF);
            p = (^d) ^ !cfg[2];
            snap();
            h.send({1'b0, d} | (9'(p) << n), n + int'(!cfg[1]), 1'b1, 1'b0);
            check(16'(last_data), 16'(d));
            if (!cfg[1])
                h.send({1'b0, d} | (9'(!p) << n), n + 1, 1'b1, 1'b0);
            counts(1, int'(!cfg[1]));
            press_key();
        end
        $display("test format done");
        wrap_up();
    end
endmodule

`default_nettype wire
